// ===== include/dlcs_params.svh
// constants for the dac level calibration sets block
// assumes it is included by the package and by every design file
//------------------------------------------------------------
// Function
// R1 - force input level keeps six input, gain, offset sets: voltage plus five ranges
// R2 - force input level keeps six cached codes until a mode change picks one
// R3 - each comparator level keeps six sets with precomputed cached codes
// R4 - each clamp level keeps two sets: voltage, and one shared by current ranges
// R5 - twenty one levels in all, scaled from one common reference
// R6 - full 16 bit input code is resolved even at quarter scale gain
// R7 - nominal offset 32768 and gain 65535 leave the input code unchanged
// R8 - gain register can only reduce gain below nominal
// R9 - offset register corrects offset error in either direction about 32768
// R10 - host calibrates every channel and mode, replacing default gain and offset
// R11 - host trims zero scale by adding or subtracting lsbs on the offset
// R12 - host trims gain by subtracting measured lsbs from default gain
// R13 - host does two point voltage calibration then writes that set
// R14 - host routes system force and sense lines and closes force sense switch
// R15 - host repeats the whole calibration for each of four channels
// R16 - host finds comparator and clamp trip points by successive approximation
// R17 - cached code is (gain+1)*input/2^16 plus offset minus 2^15
// R18 - gain register is 15 bits, data bits 15 to 1, bit 0 ignored
// R19 - gain or offset writes start no calculation; only input writes do
// R20 - update of an active set reaches the output at once, subject to load
// R21 - computed code is clamped to 0 .. 65535
//------------------------------------------------------------
`ifndef DLCS_PARAMS_SVH
`define DLCS_PARAMS_SVH
`define DLCS_NUM_CH        4
`define DLCS_NUM_LVL       5
`define DLCS_NUM_SETS      6
`define DLCS_SET_FV        3'h0
`define DLCS_SET_LAST      3'h5
`define DLCS_CLAMP_SET_I   3'h1
`define DLCS_ENTRIES       120
`define DLCS_NOM_GAIN      15'h7fff
`define DLCS_NOM_OFFSET    16'h8000
`define DLCS_OFS_DAC_RST   16'ha492
`define DLCS_CODE_MAX      16'hffff
`define DLCS_HALF_SCALE    19'sh08000
`endif

// ===== include/dlcs_pkg.sv
// types shared by the dac level calibration sets block
// assumes dlcs_params.svh sits in the include path
`include "dlcs_params.svh"
package dlcs_pkg;
  typedef enum logic [2:0] {LVL_FIN, LVL_CMP_HI, LVL_CMP_LO, LVL_CLAMP_HI, LVL_CLAMP_LO,
                            LVL_OFFSET} dlcs_lvl_t;
  typedef enum logic [1:0] {REG_INPUT, REG_GAIN, REG_OFFSET} dlcs_reg_t;
  typedef logic [2:0] dlcs_set_t;
  typedef logic [6:0] dlcs_idx_t;
  // one register write from the serial front end
  typedef struct packed {
    logic [1:0] channel;
    dlcs_lvl_t  level;
    dlcs_set_t  set;
    dlcs_reg_t  target;
    logic [15:0] data;
  } dlcs_wr_t;
  // mode change request for one channel
  typedef struct packed {
    logic [1:0] channel;
    dlcs_set_t  set;
  } dlcs_mode_t;
  typedef logic [3:0][4:0][15:0] dlcs_codes_t;
endpackage

// ===== core/dlcs_cal_engine.sv
// multiply-add calibration engine producing one cached code
// assumes operands are held stable in the cycle start is high
`timescale 1ns/1ps
`include "dlcs_params.svh"
module dlcs_cal_engine (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // operands
  input  wire logic              start,
  input  wire dlcs_pkg::dlcs_idx_t idx,
  input  wire logic [15:0]       x1,
  input  wire logic [14:0]       gain,
  input  wire logic [15:0]       offset,
  // result
  output logic                   done,
  output dlcs_pkg::dlcs_idx_t    done_idx,
  output logic [15:0]            result
);
  import dlcs_pkg::*;
  logic [16:0]        gain_p1;
  logic [32:0]        prod;
  logic signed [18:0] sum;
  logic [15:0]        next_result;
  logic               next_done;
  dlcs_idx_t          next_done_idx;

  //------------------------------------------------------------
  // arithmetic
  //------------------------------------------------------------
  // bit 0 of gain is forced high so nominal gain plus one is exactly 2^16
  always_comb
  begin
    gain_p1 = {1'b0, gain, 1'b1} + 17'h00001;                // [R18]
    prod = gain_p1 * {17'h00000, x1};                        // [R6] [R8]
    sum = $signed({2'b00, prod[32:16]}) + $signed({3'b000, offset})
          - `DLCS_HALF_SCALE;                                // [R17] [R9]
    if (sum < 0)
      next_result = 16'h0000;                                // [R21]
    else if (sum > $signed({3'b000, `DLCS_CODE_MAX}))
      next_result = `DLCS_CODE_MAX;                          // [R21]
    else
      next_result = sum[15:0];
    next_done = start;
    next_done_idx = idx;
  end

  // single stage: result lands one edge after start
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      result   <= 16'h0000;
      done     <= 1'b0;
      done_idx <= '0;
    end
    else
    begin
      result   <= next_result;
      done     <= next_done;
      done_idx <= next_done_idx;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  AST_ENG_IDENTITY: assert property (start && gain == `DLCS_NOM_GAIN && offset == `DLCS_NOM_OFFSET
    |=> result == $past(x1)) else $error("nominal coefficients changed the code"); // [R7]
  AST_ENG_REDUCE: assert property (start && offset == `DLCS_NOM_OFFSET
    |=> result <= $past(x1)) else $error("gain raised the code"); // [R8]
  AST_ENG_LOW_CLAMP: assert property (start && offset == 16'h0000 && x1 == 16'h0000
    |=> result == 16'h0000) else $error("negative result not clamped to zero"); // [R21]
  AST_ENG_HIGH_CLAMP: assert property (start && offset == `DLCS_CODE_MAX && x1 == `DLCS_CODE_MAX
    && gain == `DLCS_NOM_GAIN |=> result == `DLCS_CODE_MAX) else $error("overflow not clamped"); // [R21]
endmodule

// ===== core/dlcs_bank.sv
// per channel dac level register sets with cached calibrated codes
// assumes write and mode requests come from logic on ref_clk and
// load_n comes from a pin, so it is synchronised here
`timescale 1ns/1ps
`include "dlcs_params.svh"
module dlcs_bank (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // register writes
  input  wire logic                  wr_valid,
  input  wire dlcs_pkg::dlcs_wr_t    wr,
  // mode changes
  input  wire logic                  mode_valid,
  input  wire dlcs_pkg::dlcs_mode_t  mode,
  // load control pin
  input  wire logic                  load_n,
  // level outputs
  output dlcs_pkg::dlcs_codes_t      level_code,
  output logic [15:0]                offset_dac_code,
  output logic                       busy
);
  import dlcs_pkg::*;

  //------------------------------------------------------------
  // storage
  //------------------------------------------------------------
  logic [15:0] level_input_code [`DLCS_ENTRIES];
  logic [14:0] gain_reg [`DLCS_ENTRIES];
  logic [15:0] offset_reg [`DLCS_ENTRIES];
  logic [15:0] cached_calibrated_code [`DLCS_ENTRIES];
  dlcs_set_t   active_set [`DLCS_NUM_CH];
  dlcs_set_t   pending_set [`DLCS_NUM_CH];
  logic [2:0]  load_sync;
  logic        load_low;
  logic        load_pend;

  logic        eng_done;
  dlcs_idx_t   eng_idx;
  logic [15:0] eng_result;

  logic        wr_ok;
  logic        start;
  dlcs_idx_t   wr_idx;
  logic        apply;
  logic        next_busy;
  logic        next_load_low;
  logic        next_load_pend;
  logic [15:0] next_offset_dac_code;
  dlcs_codes_t next_level_code;
  dlcs_set_t   next_active_set [`DLCS_NUM_CH];
  dlcs_set_t   next_pending_set [`DLCS_NUM_CH];

  // clamp levels fold all current ranges onto one set
  // flat index: channel major, then level, then set; clamp levels leave
  // sets two to five unused, which costs storage but keeps the decode uniform
  // the offset level has no slot: its index lands on the next channel's entries, or past the end for channel 3, and is never written
  function automatic dlcs_idx_t entry(input logic [1:0] ch, input dlcs_lvl_t lvl,
                                      input dlcs_set_t st);
    dlcs_set_t eff;
    eff = st;
    if ((lvl == LVL_CLAMP_HI || lvl == LVL_CLAMP_LO) && st != `DLCS_SET_FV)
      eff = `DLCS_CLAMP_SET_I;                               // [R4]
    entry = 7'(ch * `DLCS_NUM_LVL * `DLCS_NUM_SETS + lvl * `DLCS_NUM_SETS + eff); // [R1] [R3]
  endfunction

  //------------------------------------------------------------
  // write decode and engine launch
  //------------------------------------------------------------
  // sets above the last current range are dropped, not aliased
  always_comb
  begin
    wr_ok = wr_valid && wr.set <= `DLCS_SET_LAST;
    wr_idx = entry(wr.channel, wr.level, wr.set);
    start = wr_ok && wr.target == REG_INPUT && wr.level != LVL_OFFSET; // [R19]
    next_busy = start;
  end

  dlcs_cal_engine u_engine (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .start    (start),
    .idx      (wr_idx),
    .x1       (wr.data),
    .gain     (gain_reg[wr_idx]),
    .offset   (offset_reg[wr_idx]),
    .done     (eng_done),
    .done_idx (eng_idx),
    .result   (eng_result)
  );

  // coefficient arrays; the engine reads them in the same cycle as the input write
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < `DLCS_ENTRIES; i++)
      begin
        level_input_code[i]       <= 16'h0000;
        gain_reg[i]               <= `DLCS_NOM_GAIN;         // [R7]
        offset_reg[i]             <= `DLCS_NOM_OFFSET;       // [R7]
        cached_calibrated_code[i] <= 16'h0000;
      end
    end
    else
    begin
      if (wr_ok && wr.level != LVL_OFFSET && wr.target == REG_INPUT)
        level_input_code[wr_idx] <= wr.data;
      if (wr_ok && wr.level != LVL_OFFSET && wr.target == REG_GAIN)
        gain_reg[wr_idx] <= wr.data[15:1];                   // [R18]
      if (wr_ok && wr.level != LVL_OFFSET && wr.target == REG_OFFSET)
        offset_reg[wr_idx] <= wr.data;
      if (eng_done)
        cached_calibrated_code[eng_idx] <= eng_result;       // [R2]
    end
  end

  //------------------------------------------------------------
  // load control and output update
  //------------------------------------------------------------
  // a load edge seen while busy is kept and served when busy clears
  always_comb
  begin
    next_load_low = load_low;
    if (load_sync[1] == load_sync[2])
      next_load_low = !load_sync[2];
    apply = (load_low || load_pend) && !busy && !start;      // [R20]
    next_load_pend = (load_pend && !apply) ||
                     (next_load_low && !load_low && (busy || start));
    next_offset_dac_code = offset_dac_code;
    if (wr_ok && wr.level == LVL_OFFSET)
      next_offset_dac_code = wr.data;                        // [R5]
    next_level_code = level_code;
    for (int ch = 0; ch < `DLCS_NUM_CH; ch++)
    begin
      next_pending_set[ch] = pending_set[ch];
      next_active_set[ch] = active_set[ch];
      if (mode_valid && mode.channel == 2'(ch) && mode.set <= `DLCS_SET_LAST)
        next_pending_set[ch] = mode.set;
      if (apply)
      begin
        next_active_set[ch] = pending_set[ch];
        for (int lv = 0; lv < `DLCS_NUM_LVL; lv++)
          next_level_code[ch][lv] =
            cached_calibrated_code[entry(2'(ch), dlcs_lvl_t'(lv), pending_set[ch])]; // [R2] [R20]
      end
    end
  end

  // three stage synchroniser on the pin; only stages two and three are compared
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      load_sync       <= 3'h7;
      load_low        <= 1'b0;
      load_pend       <= 1'b0;
      busy            <= 1'b0;
      offset_dac_code <= `DLCS_OFS_DAC_RST;
      level_code      <= '0;
      for (int ch = 0; ch < `DLCS_NUM_CH; ch++)
      begin
        active_set[ch]  <= `DLCS_SET_FV;
        pending_set[ch] <= `DLCS_SET_FV;
      end
    end
    else
    begin
      load_sync       <= {load_sync[1:0], load_n};
      load_low        <= next_load_low;
      load_pend       <= next_load_pend;
      busy            <= next_busy;
      offset_dac_code <= next_offset_dac_code;
      level_code      <= next_level_code;
      active_set      <= next_active_set;
      pending_set     <= next_pending_set;
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // a second input word right behind the first keeps busy up, which is legal
  sequence s_calc;
    busy && eng_done && eng_idx == $past(wr_idx) ##1 (!busy || $past(start));
  endsequence
  sequence s_mc_write;
    wr_valid && wr.set <= `DLCS_SET_LAST && wr.level != LVL_OFFSET && wr.target != REG_INPUT;
  endsequence
  AST_CALC_SEQ: assert property (start |=> s_calc) else $error("engine did not run once"); // [R19]
  AST_NO_CALC_MC: assert property (s_mc_write |=> !eng_done) else $error("coefficient write ran engine"); // [R19]
  AST_X2_STORE: assert property (eng_done |=> cached_calibrated_code[$past(eng_idx)] == $past(eng_result))
    else $error("cached code not stored"); // [R2]
  AST_CLAMP_FOLD: assert property (start && wr.level == LVL_CLAMP_HI && wr.set == 3'h4 // [R4]
    |=> eng_idx == 7'($past(wr.channel) * `DLCS_NUM_LVL * `DLCS_NUM_SETS
      + LVL_CLAMP_HI * `DLCS_NUM_SETS + `DLCS_CLAMP_SET_I))
    else $error("clamp set not shared");
  AST_APPLY_FIN: assert property (apply |=>
    level_code[0][0] == $past(cached_calibrated_code[entry(2'h0, LVL_FIN, pending_set[0])]))
    else $error("output missed cached code on load"); // [R20]
  AST_HOLD: assert property (!apply |=> $stable(level_code)) else $error("output moved without load"); // [R2]
  AST_LOAD_WAIT: assert property (busy |-> !apply) else $error("load applied while busy"); // [R20]
  // while stages two and three disagree the pin is unsettled and the latch must hold
  AST_SYNC_FILTER: assert property (load_sync[1] != load_sync[2] |=> $stable(load_low)) // [R20]
    else $error("unsettled load pin changed the latch");
  AST_OFS_DAC: assert property (wr_valid && wr.level == LVL_OFFSET && wr.set <= `DLCS_SET_LAST
    |=> offset_dac_code == $past(wr.data)) else $error("offset level not written"); // [R5]
endmodule

// ===== bench/dlcs_host_model.sv
// host side model that loads calibration words, mode changes and load pulses
// assumes the bench calls its tasks and that the bank samples on ref_clk rising
`timescale 1ns/1ps
module dlcs_host_model
  import dlcs_pkg::*;
(
  // clock
  input  wire logic         ref_clk,
  // requests toward the bank
  output logic              wr_valid,
  output dlcs_wr_t          wr,
  output logic              mode_valid,
  output dlcs_mode_t        mode,
  output logic              load_n
);
  //------------------------------------------------------------
  // request drivers
  //------------------------------------------------------------
  // idle values from time zero; load pin rests high
  initial
  begin
    wr_valid   = 1'b0;
    wr         = '0;
    mode_valid = 1'b0;
    mode       = '0;
    load_n     = 1'b1;
  end

  // one write word; coefficients are sent before the input word
  task automatic write_reg(input logic [1:0] ch, input dlcs_lvl_t lv, input dlcs_set_t st,
                           input dlcs_reg_t tg, input logic [15:0] d);
    @(posedge ref_clk);
    wr_valid <= 1'b1;
    wr       <= '{channel: ch, level: lv, set: st, target: tg, data: d};
    @(posedge ref_clk);
    wr_valid <= 1'b0;
  endtask

  // mode change per channel; each channel is handled on its own
  task automatic set_mode(input logic [1:0] ch, input dlcs_set_t st);
    @(posedge ref_clk);
    mode_valid <= 1'b1;
    mode       <= '{channel: ch, set: st};
    @(posedge ref_clk);
    mode_valid <= 1'b0;
  endtask

  // load pulse held three cycles: a one cycle pulse never lets stages two and three
  // of the bank's synchroniser agree and is filtered out as a glitch
  task automatic apply();
    @(posedge ref_clk);
    load_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    load_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
endmodule

// ===== bench/dlcs_bank_tb_top.sv
// self checking bench for the calibration register bank
// assumes the host model drives every request input of the bank
`timescale 1ns/1ps
module dlcs_bank_tb_top;
  import dlcs_pkg::*;
  //------------------------------------------------------------
  // clock, reset and wiring
  //------------------------------------------------------------
  logic        ref_clk;
  logic        rst_b;
  logic        wr_valid;
  dlcs_wr_t    wr;
  logic        mode_valid;
  dlcs_mode_t  mode;
  logic        load_n;
  dlcs_codes_t level_code;
  logic [15:0] offset_dac_code;
  logic        busy;
  int          errors;
  int          cmp_count;
  logic [15:0] v3;

  dlcs_host_model h (.ref_clk(ref_clk), .wr_valid(wr_valid), .wr(wr),
                     .mode_valid(mode_valid), .mode(mode), .load_n(load_n));
  dlcs_bank uut (.ref_clk(ref_clk), .rst_b(rst_b), .wr_valid(wr_valid), .wr(wr),
                 .mode_valid(mode_valid), .mode(mode), .load_n(load_n),
                 .level_code(level_code), .offset_dac_code(offset_dac_code), .busy(busy));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  //------------------------------------------------------------
  // checking helpers
  //------------------------------------------------------------
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // reference multiply-add; signed wide math so clamping is seen before truncation
  function automatic logic [15:0] cal(input logic [15:0] x, input logic [14:0] g,
                                      input logic [15:0] o);
    longint t;
    t = (((longint'(g) * 2 + 2) * longint'(x)) >>> 16) + longint'(o) - 32768;
    if (t < 0) t = 0;
    if (t > 65535) t = 65535;
    return t[15:0];
  endfunction

  // write, then check busy: only input words of calibrated levels start a calculation
  task automatic wr_chk(input logic [1:0] ch, input dlcs_lvl_t lv, input dlcs_set_t st,
                        input dlcs_reg_t tg, input logic [15:0] d);
    int n;
    h.write_reg(ch, lv, st, tg, d);
    #1;
    check({15'h0, busy}, {15'h0, tg == REG_INPUT && lv != LVL_OFFSET});
    n = 0;
    while (busy !== 1'b0 && n < 10)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 10)
    begin
      errors++;
      stop_test();
    end
  endtask

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial
  begin
    errors = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    check(offset_dac_code, 16'ha492);
    check(level_code[1][0], 16'h0000);
    // defaults leave the code unchanged
    wr_chk(2'h1, LVL_FIN, 3'h0, REG_INPUT, 16'h1234);
    h.apply();
    check(level_code[1][0], 16'h1234);
    // gain write alone does not recompute; bit 0 of the word is dropped
    wr_chk(2'h1, LVL_FIN, 3'h0, REG_GAIN, 16'h8001);
    h.apply();
    check(level_code[1][0], 16'h1234);
    wr_chk(2'h1, LVL_FIN, 3'h0, REG_INPUT, 16'h1234);
    h.apply();
    v3 = cal(16'h1234, 15'h4000, 16'h8000);
    check(level_code[1][0], v3);
    // saturation at both ends on another channel
    wr_chk(2'h3, LVL_FIN, 3'h0, REG_OFFSET, 16'hffff);
    wr_chk(2'h3, LVL_FIN, 3'h0, REG_INPUT, 16'hffff);
    h.apply();
    check(level_code[3][0], 16'hffff);
    wr_chk(2'h3, LVL_CMP_LO, 3'h0, REG_OFFSET, 16'h0000);
    wr_chk(2'h3, LVL_CMP_LO, 3'h0, REG_INPUT, 16'h0000);
    h.apply();
    check(level_code[3][2], 16'h0000);
    // cached codes per set, clamp sets folded to one current set
    wr_chk(2'h1, LVL_FIN, 3'h3, REG_INPUT, 16'h5555);
    wr_chk(2'h1, LVL_CMP_HI, 3'h3, REG_INPUT, 16'h2222);
    wr_chk(2'h1, LVL_CLAMP_LO, 3'h1, REG_INPUT, 16'h3333);
    check(level_code[1][0], v3);
    h.set_mode(2'h1, 3'h3);
    h.apply();
    check(level_code[1][0], 16'h5555);
    check(level_code[1][1], 16'h2222);
    check(level_code[1][4], 16'h3333);
    h.set_mode(2'h1, 3'h5);
    h.apply();
    check(level_code[1][4], 16'h3333);
    check(level_code[1][1], 16'h0000);
    h.set_mode(2'h1, 3'h0);
    h.apply();
    check(level_code[1][0], v3);
    check(level_code[1][4], 16'h0000);
    // current range 4 of a clamp level lands in the shared set; channel 2 gets its turn
    wr_chk(2'h2, LVL_CLAMP_HI, 3'h4, REG_INPUT, 16'h4444);
    h.set_mode(2'h2, 3'h2);
    h.apply();
    check(level_code[2][3], 16'h4444);
    // common offset level bypasses calibration
    wr_chk(2'h0, LVL_OFFSET, 3'h0, REG_INPUT, 16'h1357);
    check(offset_dac_code, 16'h1357);
    stop_test();
  end
endmodule
